// ### hdl/lpddr_cfg.svh
// Constants for the low-power DDR SDRAM command, mode and burst block
`ifndef LPDDR_CFG_SVH
`define LPDDR_CFG_SVH

// ==========================================================
// Timing
`define LPDDR_CLK_MHZ          200
`define LPDDR_INIT_WAIT_US     200
`define LPDDR_INIT_WAIT_CYC    (`LPDDR_INIT_WAIT_US * `LPDDR_CLK_MHZ)

// ==========================================================
// Array geometry
`define LPDDR_BANKS            4
`define LPDDR_ROWS_X16         8192
`define LPDDR_ROWS_X32         4096
`define LPDDR_COLS             512

// ==========================================================
// Mode register fields
`define LPDDR_MR_BL_LSB        0
`define LPDDR_MR_BT_BIT        3
`define LPDDR_MR_CL_LSB        4
`define LPDDR_MR_OPM_LSB       7
`define LPDDR_BL_CODE_2        3'h1
`define LPDDR_BL_CODE_4        3'h2
`define LPDDR_BL_CODE_8        3'h3
`define LPDDR_CL_CODE_2        3'h2
`define LPDDR_CL_CODE_3        3'h3
`define LPDDR_AP_BIT           10
`define LPDDR_BA_STD           2'h0
`define LPDDR_BA_EXT           2'h2
`define LPDDR_MR_RESET         13'h0000

// ==========================================================
// Register port
`define LPDDR_REG_STATUS       2'h0
`define LPDDR_REG_MODE         2'h1
`define LPDDR_REG_EXT          2'h2
`define LPDDR_REG_CTRL         2'h3
`define LPDDR_ST_READY_BIT     0
`define LPDDR_ST_SEQERR_BIT    1
`define LPDDR_ST_ACCERR_BIT    2
`define LPDDR_ST_MRSERR_BIT    3
`define LPDDR_ST_RSVD_BIT      4
`define LPDDR_ST_CKSTOP_BIT    5
`define LPDDR_ST_BANK_LSB      8

`endif

// ### hdl/lpddr_pkg.sv
// Types for the low-power DDR SDRAM command, mode and burst block
package lpddr_pkg;

    // ==========================================================
    // Command pins as sampled
    typedef struct packed {
        logic        cke;
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [1:0]  ba;
        logic [12:0] addr;
    } lpddr_pins_t;

    // Core access: one double-width word per core clock
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [1:0]  bank;
        logic [12:0] row;
        logic [8:0]  col_first;
        logic [8:0]  col_second;
    } lpddr_core_t;

    typedef enum logic [2:0] {
        LPDDR_CMD_NOP, LPDDR_CMD_ACT, LPDDR_CMD_RD, LPDDR_CMD_WR,
        LPDDR_CMD_BST, LPDDR_CMD_PRE, LPDDR_CMD_REF, LPDDR_CMD_LMR
    } lpddr_cmd_t;

    typedef enum {
        LPDDR_ST_POWERUP, LPDDR_ST_WANT_PRE, LPDDR_ST_WANT_REF,
        LPDDR_ST_WANT_MODES, LPDDR_ST_READY
    } lpddr_state_t;

    typedef struct packed {
        lpddr_pins_t       sync1;
        lpddr_pins_t       sync2;
        lpddr_state_t      state;
        logic [31:0]       wait_cnt;
        logic [1:0]        ref_cnt;
        logic              got_std;
        logic              got_ext;
        logic [12:0]       mode;
        logic [12:0]       ext;
        logic [3:0]        bank_open;
        logic [3:0][12:0]  rows;
        logic              bst_act;
        logic              bst_write;
        logic [1:0]        bst_bank;
        logic [8:0]        bst_start;
        logic [1:0]        bst_beat;
        logic              ctrl_x16;
        logic              seq_err;
        logic              acc_err;
        logic              mrs_err;
        logic              rsvd_mode;
        logic              ckstop_err;
        lpddr_core_t       core;
        logic [2:0]        rd_pipe;
        logic              dout_valid;
        logic [31:0]       rdata;
    } lpddr_regs_t;

endpackage : lpddr_pkg

// ### hdl/lpddr_ctrl.sv
// Command decode, initialization tracking, mode registers and burst addressing
`timescale 1ns/1ps
`include "lpddr_cfg.svh"

// Function
// - Four banks; x16 has 8192 rows, x32 4096 rows, 512 columns each.
// - Core moves one double-width word per clock, two pin transfers.
// - ACTIVE selects bank and row; READ/WRITE gives burst start column.
// - Power loss repeats initialization; no clock stop before it completes.
// - Standard mode register written by LMR with bank bits zero.
// - Standard mode register holds value until rewritten; array untouched.
// - Burst lengths 2, 4 or 8, same for reads and writes.
// - Burst wraps inside aligned block equal to burst length.
// - Sequential order: offset is start plus i modulo burst length.
// - Interleaved order: offset is start XOR i within the block.
// - Read latency programmable to two or three clocks.
// - First read data at n+1 (latency 2) or n+2 (latency 3) clocks.
// - Normal mode needs upper op-code bits zero; A0-A6 hold settings.
// - No delay-locked loop aligns output timing.
// - LMR is chip select, row, column and write strobes low, CKE high.
// - LMR with bank bits 0 low, 1 high writes the extended register.
// - Precharge acts on all banks when A10 high, else one bank.
module lpddr_ctrl #(
    parameter int unsigned INIT_WAIT_CYCLES = `LPDDR_INIT_WAIT_CYC
) (
    // Clock and reset
    input  wire logic                 mclk_i,
    input  wire logic                 reset_i,
    // Command pins from the memory controller
    input  wire lpddr_pkg::lpddr_pins_t pins_i,
    // Register port
    input  wire logic [1:0]           reg_addr_i,
    input  wire logic [31:0]          reg_wdata_i,
    input  wire logic                 reg_write_i,
    input  wire logic                 reg_read_i,
    output logic [31:0]               reg_rdata_o,
    // Core array access and read data timing
    output lpddr_pkg::lpddr_core_t    core_o,
    output logic                      dout_valid_o,
    output logic                      ready_o
);
    import lpddr_pkg::*;

    lpddr_regs_t r_reg;
    lpddr_regs_t r_next;

    // ==========================================================
    // Column of the i-th access inside an aligned block
    function automatic logic [8:0] burst_col(input logic [8:0] start, input logic [2:0] idx,
                                             input logic [2:0] mask, input logic interleave);
        logic [2:0] off;
        off = interleave ? (start[2:0] ^ idx) : 3'(start[2:0] + idx);
        burst_col = {start[8:3], (start[2:0] & ~mask) | (off & mask)};
    endfunction : burst_col

    lpddr_cmd_t  cmd;
    logic [2:0]  bl_mask;
    logic [1:0]  last_beat;
    logic        cl3;
    logic [12:0] opm_mask;
    lpddr_pins_t p;

    always_comb begin
        p = r_reg.sync2;
        // Decode only when selected with clock enable high
        cmd = LPDDR_CMD_NOP;
        if (p.cke && !p.cs_n) begin
            // Active-high strobe code {ras, cas, we}; ACTIVE and BURST TERMINATE
            // do not follow the enum order, so they are mapped by hand
            case ({~p.ras_n, ~p.cas_n, ~p.we_n})
                3'h4: begin
                    cmd = LPDDR_CMD_ACT;
                end
                3'h1: begin
                    cmd = LPDDR_CMD_BST;
                end
                default: begin
                    cmd = lpddr_cmd_t'({~p.ras_n, ~p.cas_n, ~p.we_n});
                end
            endcase
        end
        // Burst length field; reserved codes fall back to length 2
        case (r_reg.mode[`LPDDR_MR_BL_LSB +: 3])
            `LPDDR_BL_CODE_4: begin
                bl_mask   = 3'h3;
                last_beat = 2'h1;
            end
            `LPDDR_BL_CODE_8: begin
                bl_mask   = 3'h7;
                last_beat = 2'h3;
            end
            default: begin
                bl_mask   = 3'h1;
                last_beat = 2'h0;
            end
        endcase
        cl3 = (r_reg.mode[`LPDDR_MR_CL_LSB +: 3] != `LPDDR_CL_CODE_2);
        // The x32 part ignores A12 in the operating-mode field
        opm_mask = r_reg.ctrl_x16 ? 13'h1f80 : 13'h0f80;
    end

    always_comb begin
        r_next = r_reg;
        // Two flip-flops before any logic reads the pins
        r_next.sync1 = pins_i;
        r_next.sync2 = r_reg.sync1;
        r_next.core.valid = 1'b0;
        r_next.rdata = 32'h0;
        // Software clears first, so an event later in this process still sets the flag
        if (reg_write_i && reg_addr_i == `LPDDR_REG_STATUS) begin
            r_next.seq_err    = r_reg.seq_err    & ~reg_wdata_i[`LPDDR_ST_SEQERR_BIT];
            r_next.acc_err    = r_reg.acc_err    & ~reg_wdata_i[`LPDDR_ST_ACCERR_BIT];
            r_next.mrs_err    = r_reg.mrs_err    & ~reg_wdata_i[`LPDDR_ST_MRSERR_BIT];
            r_next.ckstop_err = r_reg.ckstop_err & ~reg_wdata_i[`LPDDR_ST_CKSTOP_BIT];
        end

        // ======================================================
        // Initialization tracking; reset stands in for power loss
        case (r_reg.state)
            LPDDR_ST_POWERUP: begin
                if (cmd != LPDDR_CMD_NOP) begin
                    r_next.seq_err = 1'b1;
                end
                if (r_reg.wait_cnt >= INIT_WAIT_CYCLES - 1) begin
                    r_next.state = LPDDR_ST_WANT_PRE;
                end else begin
                    r_next.wait_cnt = r_reg.wait_cnt + 32'h1;
                end
            end
            LPDDR_ST_WANT_PRE: begin
                if (cmd == LPDDR_CMD_PRE && p.addr[`LPDDR_AP_BIT]) begin
                    r_next.state = LPDDR_ST_WANT_REF;
                end else if (cmd != LPDDR_CMD_NOP) begin
                    r_next.seq_err = 1'b1;
                end
            end
            LPDDR_ST_WANT_REF: begin
                if (cmd == LPDDR_CMD_REF) begin
                    r_next.ref_cnt = r_reg.ref_cnt + 2'h1;
                    if (r_reg.ref_cnt == 2'h1) begin
                        r_next.state = LPDDR_ST_WANT_MODES;
                    end
                end else if (cmd != LPDDR_CMD_NOP) begin
                    r_next.seq_err = 1'b1;
                end
            end
            LPDDR_ST_WANT_MODES: begin
                if (cmd != LPDDR_CMD_NOP && cmd != LPDDR_CMD_LMR) begin
                    r_next.seq_err = 1'b1;
                end
                if (r_reg.got_std && r_reg.got_ext) begin
                    r_next.state = LPDDR_ST_READY;
                end
            end
            LPDDR_ST_READY: begin
            end
            default: begin
                r_next.state = LPDDR_ST_POWERUP;
            end
        endcase

        // Clock enable may only drop once initialization is done
        if (r_reg.state != LPDDR_ST_READY && !p.cke) begin
            r_next.ckstop_err = 1'b1;
        end

        // ======================================================
        // Mode register loads
        if (cmd == LPDDR_CMD_LMR && r_reg.state >= LPDDR_ST_WANT_MODES) begin
            if (r_reg.bank_open != 4'h0 || r_reg.bst_act) begin
                r_next.mrs_err = 1'b1;
            end
            if (p.ba == `LPDDR_BA_STD) begin
                r_next.mode    = p.addr;
                r_next.got_std = 1'b1;
                r_next.rsvd_mode = (p.addr & opm_mask) != 13'h0;
            end else if (p.ba == `LPDDR_BA_EXT) begin
                r_next.ext     = p.addr;
                r_next.got_ext = 1'b1;
            end else begin
                r_next.mrs_err = 1'b1;
            end
        end

        // ======================================================
        // Per-bank row state
        for (int b = 0; b < `LPDDR_BANKS; b++) begin
            if (r_reg.state == LPDDR_ST_READY && cmd == LPDDR_CMD_ACT && p.ba == 2'(b)) begin
                r_next.bank_open[b] = 1'b1;
                r_next.rows[b]      = r_reg.ctrl_x16 ? p.addr : {1'b0, p.addr[11:0]};
            end
            if (cmd == LPDDR_CMD_PRE && (p.addr[`LPDDR_AP_BIT] || p.ba == 2'(b))) begin
                r_next.bank_open[b] = 1'b0;
            end
        end

        // ======================================================
        // Burst engine: two columns per core clock
        if (r_reg.bst_act) begin
            r_next.core.valid      = 1'b1;
            r_next.core.write      = r_reg.bst_write;
            r_next.core.bank       = r_reg.bst_bank;
            r_next.core.row        = r_reg.rows[r_reg.bst_bank];
            r_next.core.col_first  = burst_col(r_reg.bst_start, {r_reg.bst_beat, 1'b0}, bl_mask,
                                               r_reg.mode[`LPDDR_MR_BT_BIT]);
            r_next.core.col_second = burst_col(r_reg.bst_start, {r_reg.bst_beat, 1'b1}, bl_mask,
                                               r_reg.mode[`LPDDR_MR_BT_BIT]);
            r_next.bst_beat = r_reg.bst_beat + 2'h1;
            if (r_reg.bst_beat == last_beat) begin
                r_next.bst_act = 1'b0;
            end
        end
        if (cmd == LPDDR_CMD_BST) begin
            r_next.bst_act = 1'b0;
        end
        // A new column command to an open bank takes over any burst in flight
        if (r_reg.state == LPDDR_ST_READY && (cmd == LPDDR_CMD_RD || cmd == LPDDR_CMD_WR)) begin
            if (!r_reg.bank_open[p.ba]) begin
                r_next.acc_err = 1'b1;
            end else begin
                r_next.bst_act   = 1'b1;
                r_next.bst_write = (cmd == LPDDR_CMD_WR);
                r_next.bst_bank  = p.ba;
                r_next.bst_start = p.addr[8:0];
                r_next.bst_beat  = 2'h0;
            end
        end

        // ======================================================
        // Read latency: data valid with the beat (latency 2) or one clock after it (latency 3);
        // there is no delay-locked loop, so timing is cycle based only
        r_next.rd_pipe    = {r_reg.rd_pipe[1:0], r_reg.bst_act & ~r_reg.bst_write};
        r_next.dout_valid = cl3 ? r_reg.rd_pipe[0] : (r_reg.bst_act & ~r_reg.bst_write);

        // ======================================================
        // Register port
        if (reg_write_i && reg_addr_i == `LPDDR_REG_CTRL) begin
            r_next.ctrl_x16 = reg_wdata_i[0];
        end
        if (reg_read_i) begin
            case (reg_addr_i)
                `LPDDR_REG_STATUS: begin
                    r_next.rdata[`LPDDR_ST_READY_BIT]  = (r_reg.state == LPDDR_ST_READY);
                    r_next.rdata[`LPDDR_ST_SEQERR_BIT] = r_reg.seq_err;
                    r_next.rdata[`LPDDR_ST_ACCERR_BIT] = r_reg.acc_err;
                    r_next.rdata[`LPDDR_ST_MRSERR_BIT] = r_reg.mrs_err;
                    r_next.rdata[`LPDDR_ST_RSVD_BIT]   = r_reg.rsvd_mode;
                    r_next.rdata[`LPDDR_ST_CKSTOP_BIT] = r_reg.ckstop_err;
                    r_next.rdata[`LPDDR_ST_BANK_LSB +: 4] = r_reg.bank_open;
                end
                `LPDDR_REG_MODE: begin
                    r_next.rdata[12:0] = r_reg.mode;
                end
                `LPDDR_REG_EXT: begin
                    r_next.rdata[12:0] = r_reg.ext;
                end
                `LPDDR_REG_CTRL: begin
                    r_next.rdata[0] = r_reg.ctrl_x16;
                end
                default: begin
                    r_next.rdata = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            r_reg       <= '0;
            r_reg.state <= LPDDR_ST_POWERUP;
            r_reg.mode  <= `LPDDR_MR_RESET;
            r_reg.ext   <= `LPDDR_MR_RESET;
            // Idle pins deselect until the synchroniser fills
            r_reg.sync1.cs_n <= 1'b1;
            r_reg.sync2.cs_n <= 1'b1;
            r_reg.sync1.cke  <= 1'b1;
            r_reg.sync2.cke  <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign reg_rdata_o  = r_reg.rdata;
    assign core_o       = r_reg.core;
    assign dout_valid_o = r_reg.dout_valid;
    assign ready_o      = (r_reg.state == LPDDR_ST_READY);

endmodule : lpddr_ctrl

// ### tb/lpddr_ctrl_checker.sv
// Concurrent checks on the ports of the LPDDR command and burst block
`timescale 1ns/1ps

module lpddr_ctrl_checker
    import lpddr_pkg::*;
#(
    parameter int unsigned INIT_WAIT_CYCLES = 20
) (
    // Clock and reset
    input wire logic                   mclk_i,
    input wire logic                   reset_i,
    // Watched ports
    input wire lpddr_pkg::lpddr_pins_t pins_i,
    input wire logic                   reg_read_i,
    input wire logic [31:0]            reg_rdata_o,
    input wire lpddr_pkg::lpddr_core_t core_o,
    input wire logic                   dout_valid_o,
    input wire logic                   ready_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    // ==========================================================
    // Helper logic
    // Saturates so a long run never wraps back under the startup wait
    logic [31:0] up_cnt_reg;
    logic        col_cmd;
    assign col_cmd = pins_i.cke && !pins_i.cs_n && pins_i.ras_n && !pins_i.cas_n;
    always_ff @(posedge mclk_i) begin
        if (reset_i) up_cnt_reg <= '0;
        else if (up_cnt_reg != 32'hffffffff) up_cnt_reg <= up_cnt_reg + 32'h1;
    end

    // ==========================================================
    // Properties
    property p_reset_clear;
        $fell(reset_i) |-> !ready_o && !core_o.valid && !dout_valid_o && reg_rdata_o == 32'h0;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear after reset");

    property p_ready_hold;
        ready_o |=> ready_o;
    endproperty
    a_ready_hold: assert property (p_ready_hold) else $error("ready dropped without reset");

    property p_ready_late;
        $rose(ready_o) |-> up_cnt_reg >= INIT_WAIT_CYCLES;
    endproperty
    a_ready_late: assert property (p_ready_late) else $error("ready before startup wait");

    property p_core_needs_ready;
        core_o.valid |-> ready_o;
    endproperty
    a_core_needs_ready: assert property (p_core_needs_ready) else $error("access before ready");

    property p_col_start;
        col_cmd && ready_o |-> ##[2:4] core_o.valid;
    endproperty
    a_col_start: assert property (p_col_start) else $error("burst did not start");

    property p_pair_block;
        core_o.valid |-> core_o.col_second[8:3] == core_o.col_first[8:3]
                         && core_o.col_second[0] != core_o.col_first[0];
    endproperty
    a_pair_block: assert property (p_pair_block) else $error("beat pair leaves its block");

    property p_dout_cause;
        dout_valid_o |-> (core_o.valid && !core_o.write) || $past(core_o.valid && !core_o.write);
    endproperty
    a_dout_cause: assert property (p_dout_cause) else $error("read data without read beat");

    property p_rdata_idle;
        !$past(reg_read_i) |-> reg_rdata_o == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");

endmodule : lpddr_ctrl_checker

// ### tb/lpddr_mc_model.sv
// Memory controller model driving the SDRAM command pins
`timescale 1ns/1ps

module lpddr_mc_model
    import lpddr_pkg::*;
(
    // Clock
    input  wire logic                  mclk_i,
    // Command pins
    output lpddr_pkg::lpddr_pins_t     pins_o
);
    initial pins_o = {1'b1, 1'b0, 3'b111, 2'h0, 13'h0000};

    // Idle address lines flip every cycle so stale values are never trusted
    task automatic nop(input int n);
        repeat (n) begin
            @(posedge mclk_i);
            pins_o <= {1'b1, 1'b0, 3'b111, ~pins_o.ba, ~pins_o.addr};
        end
    endtask : nop

    task automatic issue(input lpddr_cmd_t c, input logic [1:0] ba, input logic [12:0] a);
        logic [2:0] s;
        case (c)
            LPDDR_CMD_ACT: s = 3'b011;
            LPDDR_CMD_RD:  s = 3'b101;
            LPDDR_CMD_WR:  s = 3'b100;
            LPDDR_CMD_BST: s = 3'b110;
            LPDDR_CMD_PRE: s = 3'b010;
            LPDDR_CMD_REF: s = 3'b001;
            LPDDR_CMD_LMR: s = 3'b000;
            default:       s = 3'b111;
        endcase
        @(posedge mclk_i);
        pins_o <= {1'b1, 1'b0, s, ba, a};
        nop(1);
    endtask : issue

    // ==========================================================
    // Power-up sequence
    task automatic init(input int w, input logic [12:0] mode, input logic [12:0] ext);
        nop(w);
        issue(LPDDR_CMD_PRE, 2'h0, 13'h0400);
        nop(2);
        issue(LPDDR_CMD_REF, 2'h0, 13'h0000);
        nop(3);
        issue(LPDDR_CMD_REF, 2'h0, 13'h0000);
        nop(3);
        issue(LPDDR_CMD_LMR, 2'h0, mode);
        nop(2);
        issue(LPDDR_CMD_LMR, 2'h2, ext);
        nop(2);
    endtask : init

endmodule : lpddr_mc_model

// ### tb/tb_top.sv
// Self-checking testbench for the LPDDR command and burst block
`timescale 1ns/1ps

module tb_top;
    import lpddr_pkg::*;
    localparam int unsigned INIT_WAIT = 20;

    logic        mclk_i, reset_i, reg_write_i, reg_read_i, dout_valid_o, ready_o;
    logic [1:0]  reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, d;
    lpddr_pins_t pins;
    lpddr_core_t core_o;
    lpddr_core_t beats[$];
    int          beat_cyc[$], dv_cyc[$];
    int          cyc, fail_count, cmp_count;

    lpddr_ctrl #(.INIT_WAIT_CYCLES(INIT_WAIT)) dut (
        .mclk_i(mclk_i), .reset_i(reset_i), .pins_i(pins), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
        .reg_rdata_o(reg_rdata_o), .core_o(core_o), .dout_valid_o(dout_valid_o), .ready_o(ready_o));
    lpddr_mc_model mc (.mclk_i(mclk_i), .pins_o(pins));

    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    always @(posedge mclk_i) begin
        cyc++;
        if (core_o.valid === 1'b1) begin
            beats.push_back(core_o);
            beat_cyc.push_back(cyc);
        end
        if (dout_valid_o === 1'b1) dv_cyc.push_back(cyc);
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    task automatic do_reset();
        reset_i <= 1'b1;
        repeat (20) @(posedge mclk_i);
        reset_i <= 1'b0;
        @(posedge mclk_i);
    endtask : do_reset

    task automatic reg_wr(input logic [1:0] a, input logic [31:0] v);
        @(posedge mclk_i);
        {reg_write_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, v};
        @(posedge mclk_i);
        reg_write_i <= 1'b0;
    endtask : reg_wr

    // Read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [1:0] a, output logic [31:0] v);
        @(posedge mclk_i);
        {reg_read_i, reg_addr_i} <= {1'b1, a};
        @(posedge mclk_i);
        reg_read_i <= 1'b0;
        #1 v = reg_rdata_o;
    endtask : reg_rd

    task automatic lmr_check(input logic [1:0] ba, input logic [12:0] a, input logic [31:0] st);
        mc.issue(LPDDR_CMD_LMR, ba, a);
        mc.nop(2);
        reg_rd(2'h0, d);
        chk("status", d & 32'h18, st);
    endtask : lmr_check

    // ==========================================================
    // One burst checked against the wrap and order model
    task automatic run_burst(input int blc, input int bt, input int cl, input int wr);
        int bl, n, bank, row, col, off, e;
        logic [12:0] mode;
        bl = 1 << blc;
        n = bl / 2;
        mode = {6'h00, 3'(cl), 1'(bt), 3'(blc)};
        bank = $urandom % 4;
        row = $urandom % 8192;
        col = $urandom % 512;
        mc.issue(LPDDR_CMD_PRE, 2'h0, 13'h0400);
        mc.issue(LPDDR_CMD_LMR, 2'h0, mode);
        mc.nop(2);
        reg_rd(2'h1, d);
        chk("mode", d, {19'h0, mode});
        mc.issue(LPDDR_CMD_ACT, 2'(bank), 13'(row));
        beats.delete();
        beat_cyc.delete();
        dv_cyc.delete();
        mc.issue(wr ? LPDDR_CMD_WR : LPDDR_CMD_RD, 2'(bank), 13'(col));
        for (int t = 0; t < 40 && beats.size() < n; t++) @(posedge mclk_i);
        repeat (6) @(posedge mclk_i);
        chk("beat_count", beats.size(), n);
        if (beats.size() != n) tally_and_finish();
        for (int i = 0; i < bl; i++) begin
            off = bt ? ((col ^ i) & (bl - 1)) : ((col + i) % bl);
            e = (col & ~(bl - 1)) | off;
            if (i % 2 == 0) chk("col_first", beats[i/2].col_first, e);
            else chk("col_second", beats[i/2].col_second, e);
        end
        chk("bank", beats[0].bank, bank);
        chk("row", beats[0].row, row);
        chk("write", beats[0].write, wr);
        chk("dout_count", dv_cyc.size(), wr ? 0 : n);
        if (!wr && dv_cyc.size() > 0) chk("dout_lat", dv_cyc[0] - beat_cyc[0], cl - 2);
    endtask : run_burst

    // ==========================================================
    // Main sequence
    initial begin
        {reset_i, reg_write_i, reg_read_i, reg_addr_i, reg_wdata_i} = {3'b100, 2'h0, 32'h0};
        void'($urandom(32'hb244ed8a));
        do_reset();
        chk("ready_early", ready_o, 0);
        mc.issue(LPDDR_CMD_ACT, 2'h1, 13'h0011);
        mc.nop(2);
        reg_rd(2'h0, d);
        chk("seq_err", d[1], 1);
        reg_wr(2'h0, 32'h2);
        reg_rd(2'h0, d);
        chk("seq_err_clr", d[1], 0);
        // Second reset stands in for a power loss in mid-run
        do_reset();
        mc.init(INIT_WAIT + 5, 13'h0032, 13'h0000);
        for (int t = 0; t < 200 && ready_o !== 1'b1; t++) @(posedge mclk_i);
        if (ready_o !== 1'b1) fail_count++;
        if (ready_o !== 1'b1) tally_and_finish();
        reg_rd(2'h0, d);
        chk("status_ready", d, 32'h1);
        lmr_check(2'h1, 13'h0000, 32'h08);
        reg_wr(2'h0, 32'h8);
        lmr_check(2'h2, 13'h0055, 32'h00);
        reg_rd(2'h1, d);
        chk("mode_kept", d, 32'h32);
        reg_rd(2'h2, d);
        chk("ext", d, 32'h55);
        lmr_check(2'h0, 13'h00b2, 32'h10);
        lmr_check(2'h0, 13'h0032, 32'h00);
        // A12 is outside the operating-mode field on the x32 part only
        lmr_check(2'h0, 13'h1032, 32'h00);
        reg_wr(2'h3, 32'h1);
        reg_rd(2'h3, d);
        chk("ctrl_x16", d, 32'h1);
        lmr_check(2'h0, 13'h1032, 32'h10);
        lmr_check(2'h0, 13'h0032, 32'h00);
        for (int b = 1; b <= 3; b++)
            for (int t = 0; t < 2; t++)
                for (int c = 2; c <= 3; c++)
                    for (int w = 0; w < 2; w++) run_burst(b, t, c, w);
        // Burst terminate two cycles behind a length-8 read leaves two beats
        beats.delete();
        mc.issue(LPDDR_CMD_ACT, 2'h0, 13'h0000);
        mc.issue(LPDDR_CMD_RD, 2'h0, 13'h0000);
        mc.issue(LPDDR_CMD_BST, 2'h0, 13'h0000);
        repeat (10) @(posedge mclk_i);
        chk("bst_cut", beats.size(), 2);
        tally_and_finish();
    end

endmodule : tb_top

bind lpddr_ctrl lpddr_ctrl_checker #(.INIT_WAIT_CYCLES(INIT_WAIT_CYCLES)) u_chk (
    .mclk_i(mclk_i), .reset_i(reset_i), .pins_i(pins_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .core_o(core_o), .dout_valid_o(dout_valid_o), .ready_o(ready_o));
